/* pkg/btg_map.svh */
// Register offsets, field positions, reset values and timing counts of the
// beep tone generator.
// Assumes an eight-bit register address space inside the codec.
`ifndef BTG_MAP_SVH
`define BTG_MAP_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define BTG_FREQ_MODE_OFS 8'h20
`define BTG_ON_DUR_OFS 8'h21
`define BTG_OFF_DUR_OFS 8'h22
`define BTG_BURST_CNT_OFS 8'h23
`define BTG_LEVEL_TRIG_OFS 8'h24

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define BTG_REPEAT_MODE_BIT 7
`define BTG_FREQ_SEL_MSB 1
`define BTG_BURST_CNT_MSB 6
`define BTG_TRIGGER_BIT 7
`define BTG_LEVEL_MSB 2

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define BTG_REPEAT_MODE_RST 1'h0
`define BTG_FREQ_SEL_RST 2'h0
`define BTG_ON_DUR_RST 8'h00
`define BTG_OFF_DUR_RST 8'h00
`define BTG_BURST_CNT_RST 7'h00
`define BTG_LEVEL_RST 3'h0
`define BTG_TRIGGER_RST 1'h0

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define BTG_CLK_PERIOD_NS 10
`define BTG_TICK_TIME_NS 1000000
`define BTG_TICK_CYCLES (`BTG_TICK_TIME_NS / `BTG_CLK_PERIOD_NS)

`endif

/* pkg/btg_pkg.sv */
// Types shared by the beep tone generator modules.
// Assumes nothing beyond a SystemVerilog compiler.
package btg_pkg;

  // ----------------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    BTG_IDLE,
    BTG_TONE,
    BTG_GAP
  } btg_state_e;

  typedef logic [7:0] btg_byte_t;

endpackage

/* src/btg_dur_timer.sv */
// Duration timer: counts (code + 1) ticks of TICK_CYCLES clock cycles each.
// Assumes load is a single-cycle strobe from the sequencer; clear is held high while it is idle.
`timescale 1ns/1ps

module btg_dur_timer #(
  parameter int TICK_CYCLES = 100000
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic load,
  input wire logic clear,
  input wire logic [7:0] dur_code,
  output logic done
);

  logic [31:0] tick_cnt;
  logic [8:0] unit_cnt;
  logic busy;

  // ----------------------------------------------------------------------
  // Tick prescaler and unit counter
  // ----------------------------------------------------------------------
  // A code of zero still lasts one tick, so a phase is never skipped.
  always_ff @(posedge clk_sys) begin
    done <= 1'b0;
    if (!rst_n || clear) begin
      tick_cnt <= 32'h0000_0000;
      unit_cnt <= 9'h000;
      busy <= 1'b0;
    end else if (load) begin
      tick_cnt <= 32'h0000_0000;
      unit_cnt <= {1'b0, dur_code} + 9'h001;
      busy <= 1'b1;
    end else if (busy) begin
      if (tick_cnt == 32'(TICK_CYCLES - 1)) begin
        tick_cnt <= 32'h0000_0000;
        if (unit_cnt == 9'h001) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          unit_cnt <= unit_cnt - 9'h001;
        end
      end else begin
        tick_cnt <= tick_cnt + 32'h0000_0001;
      end
    end
  end

  a_done_busy: assert property (@(posedge clk_sys) disable iff (!rst_n)
    done |-> $past(busy)) else $error("Timer done without a running count.");

endmodule // btg_dur_timer

/* src/btg_top.sv */
// Beep tone generator: register set, burst sequencer and square-wave tone.
// Assumes a synchronous internal register port with one-cycle strobes.
//
// What this block does
// - Repeat-mode bit: zero single, one continuous.
// - Continuous mode plays while repeat bit set.
// - Single mode plays exactly burst-count bursts.
// - Eight-bit on-duration field, read/write, resets zero.
// - Eight-bit off-duration field, read/write, resets zero.
// - Seven-bit burst count; bit seven reads zero.
// - Three-bit level field; bits six-three read zero.
// - Trigger bit seven of control; resets off.
// - Single mode starts when trigger written one.
// - After last burst, stop and clear trigger.
// - Two-bit frequency select beside repeat-mode bit.
`timescale 1ns/1ps
`include "btg_map.svh"

module btg_top
  import btg_pkg::*;
#(
  parameter int TICK_CYCLES = `BTG_TICK_CYCLES,
  parameter int HALF_PER_0 = 50000,
  parameter int HALF_PER_1 = 25000,
  parameter int HALF_PER_2 = 12500,
  parameter int HALF_PER_3 = 6250
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic tone_wave,
  output logic tone_on,
  output logic [2:0] tone_output_level,
  output logic [1:0] tone_frequency_select
);

  logic tone_repeat_mode;
  btg_byte_t tone_on_duration;
  btg_byte_t tone_off_duration;
  logic [6:0] tone_burst_count;
  logic tone_trigger;
  btg_state_e state;
  btg_state_e next_state;
  logic [6:0] bursts_done;
  logic hw_clear;
  logic timer_load;
  logic timer_clear;
  logic timer_done;
  logic [31:0] wave_cnt;
  logic [31:0] half_per;
  logic wr_freq, wr_on, wr_off, wr_cnt, wr_ctl;
  logic last_burst;

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  assign wr_freq = reg_wr && (reg_addr == `BTG_FREQ_MODE_OFS);
  assign wr_on = reg_wr && (reg_addr == `BTG_ON_DUR_OFS);
  assign wr_off = reg_wr && (reg_addr == `BTG_OFF_DUR_OFS);
  assign wr_cnt = reg_wr && (reg_addr == `BTG_BURST_CNT_OFS);
  assign wr_ctl = reg_wr && (reg_addr == `BTG_LEVEL_TRIG_OFS);

  // ----------------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------------
  // Mode and frequency select share one register.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      tone_repeat_mode <= `BTG_REPEAT_MODE_RST;
      tone_frequency_select <= `BTG_FREQ_SEL_RST;
    end else if (wr_freq) begin
      tone_repeat_mode <= reg_wdata[`BTG_REPEAT_MODE_BIT];
      tone_frequency_select <= reg_wdata[`BTG_FREQ_SEL_MSB:0];
    end
  end

  // Duration and count fields.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      tone_on_duration <= `BTG_ON_DUR_RST;
      tone_off_duration <= `BTG_OFF_DUR_RST;
      tone_burst_count <= `BTG_BURST_CNT_RST;
    end else begin
      if (wr_on) tone_on_duration <= reg_wdata;
      if (wr_off) tone_off_duration <= reg_wdata;
      if (wr_cnt) tone_burst_count <= reg_wdata[`BTG_BURST_CNT_MSB:0];
    end
  end

  // Level and trigger. A software write in the same cycle as the
  // self-clear wins, so a fresh start request is never lost.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      tone_output_level <= `BTG_LEVEL_RST;
      tone_trigger <= `BTG_TRIGGER_RST;
    end else if (wr_ctl) begin
      tone_output_level <= reg_wdata[`BTG_LEVEL_MSB:0];
      tone_trigger <= reg_wdata[`BTG_TRIGGER_BIT];
    end else if (hw_clear) begin
      tone_trigger <= 1'b0;
    end
  end

  // Registered read data; unmapped addresses read zero.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `BTG_FREQ_MODE_OFS: reg_rdata <= {tone_repeat_mode, 5'h00, tone_frequency_select};
        `BTG_ON_DUR_OFS: reg_rdata <= tone_on_duration;
        `BTG_OFF_DUR_OFS: reg_rdata <= tone_off_duration;
        `BTG_BURST_CNT_OFS: reg_rdata <= {1'b0, tone_burst_count};
        `BTG_LEVEL_TRIG_OFS: reg_rdata <= {tone_trigger, 4'h0, tone_output_level};
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Burst sequencer
  // ----------------------------------------------------------------------
  assign last_burst = !tone_repeat_mode && ((bursts_done + 7'h01) >= tone_burst_count);

  // Next state and the self-clear strobe.
  always_comb begin
    next_state = state;
    hw_clear = 1'b0;
    case (state)
      BTG_IDLE: begin
        if (tone_repeat_mode) begin
          next_state = BTG_TONE;
        end else if (tone_trigger) begin
          if (tone_burst_count != 7'h00) begin
            next_state = BTG_TONE;
          end else begin
            hw_clear = 1'b1;
          end
        end
      end
      BTG_TONE: begin
        if (!tone_repeat_mode && !tone_trigger) begin
          next_state = BTG_IDLE;
        end else if (timer_done) begin
          next_state = BTG_GAP;
        end
      end
      BTG_GAP: begin
        if (!tone_repeat_mode && !tone_trigger) begin
          next_state = BTG_IDLE;
        end else if (timer_done) begin
          if (last_burst) begin
            next_state = BTG_IDLE;
            hw_clear = 1'b1;
          end else begin
            next_state = BTG_TONE;
          end
        end
      end
      default: next_state = BTG_IDLE;
    endcase
  end

  assign timer_load = (next_state != state) && (next_state != BTG_IDLE);
  assign timer_clear = (next_state == BTG_IDLE);

  // State, tone-on flag and completed-burst counter.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state <= BTG_IDLE;
      tone_on <= 1'b0;
      bursts_done <= 7'h00;
    end else begin
      state <= next_state;
      tone_on <= (next_state == BTG_TONE);
      if (next_state == BTG_IDLE) begin
        bursts_done <= 7'h00;
      end else if (state == BTG_GAP && next_state == BTG_TONE && !tone_repeat_mode) begin
        bursts_done <= bursts_done + 7'h01;
      end
    end
  end

  btg_dur_timer #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_timer (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .load(timer_load),
    .clear(timer_clear),
    .dur_code((next_state == BTG_GAP) ? tone_off_duration : tone_on_duration),
    .done(timer_done)
  );

  // ----------------------------------------------------------------------
  // Square-wave tone
  // ----------------------------------------------------------------------
  // Half periods stand in for the frequency table until it is fixed.
  always_comb begin
    case (tone_frequency_select)
      2'h0: half_per = 32'(HALF_PER_0);
      2'h1: half_per = 32'(HALF_PER_1);
      2'h2: half_per = 32'(HALF_PER_2);
      default: half_per = 32'(HALF_PER_3);
    endcase
  end

  // Wave restarts low at each burst so every burst starts the same way.
  always_ff @(posedge clk_sys) begin
    if (!rst_n || next_state != BTG_TONE) begin
      wave_cnt <= 32'h0000_0000;
      tone_wave <= 1'b0;
    end else if (wave_cnt >= half_per - 32'h0000_0001) begin
      wave_cnt <= 32'h0000_0000;
      tone_wave <= !tone_wave;
    end else begin
      wave_cnt <= wave_cnt + 32'h0000_0001;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence s_tone_end;
    state == BTG_TONE && timer_done && (tone_repeat_mode || tone_trigger);
  endsequence

  a_mode_write: assert property (wr_freq |=>
    tone_repeat_mode == $past(reg_wdata[7]) && tone_frequency_select == $past(reg_wdata[1:0]))
    else $error("Mode or frequency write not stored.");
  a_cont_start: assert property (state == BTG_IDLE && tone_repeat_mode |=>
    state == BTG_TONE && tone_on) else $error("Continuous mode did not start.");
  a_early_stop: assert property (state != BTG_IDLE && !tone_repeat_mode && !tone_trigger
    |=> state == BTG_IDLE && !tone_on && bursts_done == 7'h00)
    else $error("Tone did not stop at once.");
  // Only a live single run is bounded: a run that was just stopped still sits one edge
  // in a busy state, with the count possibly zero.
  a_burst_limit: assert property (state != BTG_IDLE && !tone_repeat_mode
    && tone_trigger |-> bursts_done < tone_burst_count) else $error("Burst count exceeded.");
  a_on_write: assert property (wr_on ##1 (reg_rd && reg_addr == `BTG_ON_DUR_OFS && !reg_wr)
    |=> reg_rdata == $past(reg_wdata, 2)) else $error("On-duration readback wrong.");
  a_off_write: assert property (wr_off |=> tone_off_duration == $past(reg_wdata))
    else $error("Off-duration not stored.");
  a_cnt_top: assert property (reg_rd && reg_addr == `BTG_BURST_CNT_OFS |=>
    reg_rdata[7] == 1'b0) else $error("Burst count bit seven not zero.");
  a_ctl_zero: assert property (reg_rd && reg_addr == `BTG_LEVEL_TRIG_OFS |=>
    reg_rdata[6:3] == 4'h0 && reg_rdata[7] == $past(tone_trigger))
    else $error("Control register readback wrong.");
  a_trig_start: assert property (state == BTG_IDLE && !tone_repeat_mode && tone_trigger
    && tone_burst_count != 7'h00 |=> tone_on) else $error("Trigger did not start tone.");
  a_self_clear: assert property (hw_clear && !wr_ctl |=> !tone_trigger
    && state == BTG_IDLE) else $error("Trigger not cleared after bursts.");
  a_on_then_off: assert property (s_tone_end |=> state == BTG_GAP && !tone_on
    && !tone_wave) else $error("Off phase did not follow on phase.");

endmodule // btg_top

/* tb/btg_top_tb_top.sv */
// Self-checking bench for the beep tone generator: registers, bursts, modes, abort.
// Assumes btg_top with a short tick so that whole burst sequences fit in a short run.
`timescale 1ns/1ps
`include "btg_map.svh"

module btg_top_tb_top
  import btg_pkg::*;
;
  localparam int TK = 2;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic tone_wave;
  logic tone_on;
  logic [2:0] tone_output_level;
  logic [1:0] tone_frequency_select;
  int failures = 0;
  int cmp_count = 0;
  int cyc = 0;
  int rises = 0;
  int high = 0;
  int wave_rise = 0;
  logic prev_on = 1'b0;
  logic prev_wave = 1'b0;
  btg_byte_t rv;

  btg_top #(.TICK_CYCLES(TK), .HALF_PER_0(2), .HALF_PER_1(3), .HALF_PER_2(4),
    .HALF_PER_3(5)) uut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .tone_wave(tone_wave), .tone_on(tone_on), .tone_output_level(tone_output_level),
    .tone_frequency_select(tone_frequency_select));

  // Free-running 100 MHz clock.
  always #5 clk_sys = ~clk_sys;

  // ----------------------------------------------------------------------
  // Output monitor and hang guard
  // ----------------------------------------------------------------------
  // Samples before the design's updates land, so every edge sees settled values.
  always @(posedge clk_sys) begin
    cyc++;
    if (tone_on === 1'b1) high++;
    if (tone_on === 1'b1 && prev_on !== 1'b1) rises++;
    if (tone_wave === 1'b1 && prev_wave !== 1'b1) wave_rise++;
    prev_on = tone_on;
    prev_wave = tone_wave;
    if (cyc >= 4000) begin
      failures++;
      report_and_stop();
    end
  end

  // ----------------------------------------------------------------------
  // Register port and compare helpers
  // ----------------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk_sys);
    reg_wr = 1'b0;
  endtask

  // Read data is registered, so it is taken one edge after the strobe.
  task automatic rd(input logic [7:0] a, output btg_byte_t d);
    @(negedge clk_sys);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    d = reg_rdata;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("FAIL %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string msg);
    rd(a, rv);
    chk(rv, exp, msg);
  endtask

  task automatic clr_mon();
    @(negedge clk_sys);
    rises = 0;
    high = 0;
    wave_rise = 0;
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset();
    rd_chk(`BTG_FREQ_MODE_OFS, 8'h00, "reset mode");
    rd_chk(`BTG_ON_DUR_OFS, 8'h00, "reset on");
    rd_chk(`BTG_OFF_DUR_OFS, 8'h00, "reset off");
    rd_chk(`BTG_BURST_CNT_OFS, 8'h00, "reset count");
    rd_chk(`BTG_LEVEL_TRIG_OFS, 8'h00, "reset ctrl");
    $display("test reset done");
  endtask

  // Read-only bits must ignore writes of ones; unmapped space reads zero.
  task automatic t_regs();
    wr(`BTG_FREQ_MODE_OFS, 8'h7F);
    wr(`BTG_ON_DUR_OFS, 8'hA5);
    wr(`BTG_OFF_DUR_OFS, 8'h5A);
    wr(`BTG_BURST_CNT_OFS, 8'hFF);
    wr(`BTG_LEVEL_TRIG_OFS, 8'h7F);
    wr(8'h25, 8'hFF);
    rd_chk(`BTG_FREQ_MODE_OFS, 8'h03, "mode rb");
    chk(8'(tone_frequency_select), 8'h03, "freq out");
    rd_chk(`BTG_ON_DUR_OFS, 8'hA5, "on rb");
    // Write then read on the very next edge: the read must see the new value.
    @(negedge clk_sys);
    reg_wr = 1'b1;
    reg_addr = `BTG_ON_DUR_OFS;
    reg_wdata = 8'h3C;
    @(negedge clk_sys);
    reg_wr = 1'b0;
    reg_rd = 1'b1;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    chk(reg_rdata, 8'h3C, "on back to back");
    rd_chk(`BTG_OFF_DUR_OFS, 8'h5A, "off rb");
    rd_chk(`BTG_BURST_CNT_OFS, 8'h7F, "count rb");
    rd_chk(`BTG_LEVEL_TRIG_OFS, 8'h07, "ctrl rb");
    chk(8'(tone_output_level), 8'h07, "level out");
    rd_chk(8'h25, 8'h00, "unmapped");
    chk(8'(rises), 8'h00, "no tone");
    wr(`BTG_FREQ_MODE_OFS, 8'h00);
    $display("test regs done");
  endtask

  // Single mode: exactly n bursts of the on length, then trigger reads zero.
  // The wave toggles every hp cycles of each on phase and starts low in each burst.
  task automatic t_bursts(input int n, input int on, input int off, input logic [2:0] lv,
    input int hp);
    wr(`BTG_ON_DUR_OFS, 8'(on));
    wr(`BTG_OFF_DUR_OFS, 8'(off));
    wr(`BTG_BURST_CNT_OFS, 8'(n));
    clr_mon();
    wr(`BTG_LEVEL_TRIG_OFS, {5'h10, lv});
    repeat (n * ((on + 1) * TK + (off + 1) * TK + 2) + 4) @(negedge clk_sys);
    chk(8'(rises), 8'(n), "burst count");
    chk(8'(high), 8'(n * ((on + 1) * TK + 1)), "on cycles");
    chk(8'(wave_rise), 8'(n * ((((on + 1) * TK + 1) / hp + 1) / 2)), "wave");
    rd_chk(`BTG_LEVEL_TRIG_OFS, {5'h00, lv}, "self clear");
    $display("test bursts %0d done", n);
  endtask

  // Continuous mode runs while the mode bit is one and stops when it clears.
  task automatic t_cont();
    wr(`BTG_ON_DUR_OFS, 8'h00);
    wr(`BTG_OFF_DUR_OFS, 8'h00);
    clr_mon();
    wr(`BTG_FREQ_MODE_OFS, 8'h80);
    repeat (40) @(negedge clk_sys);
    chk(8'(rises >= 6), 8'h01, "continuous");
    rd_chk(`BTG_FREQ_MODE_OFS, 8'h80, "mode bit");
    wr(`BTG_FREQ_MODE_OFS, 8'h00);
    @(negedge clk_sys);
    chk(8'(tone_on), 8'h00, "cont stop");
    clr_mon();
    repeat (20) @(negedge clk_sys);
    chk(8'(rises), 8'h00, "stays off");
    $display("test continuous done");
  endtask

  // Clearing the trigger mid-burst stops at once; a new run starts from scratch.
  task automatic t_abort();
    wr(`BTG_ON_DUR_OFS, 8'h03);
    wr(`BTG_BURST_CNT_OFS, 8'h05);
    wr(`BTG_LEVEL_TRIG_OFS, 8'h80);
    rd_chk(`BTG_LEVEL_TRIG_OFS, 8'h80, "trigger on");
    repeat (5) @(negedge clk_sys);
    wr(`BTG_LEVEL_TRIG_OFS, 8'h00);
    @(negedge clk_sys);
    chk(8'(tone_on), 8'h00, "abort stop");
    clr_mon();
    repeat (30) @(negedge clk_sys);
    chk(8'(rises), 8'h00, "abort quiet");
    // The fresh run also uses the slowest tone code, so its half period is seen on the wave.
    wr(`BTG_FREQ_MODE_OFS, 8'h03);
    t_bursts(1, 2, 1, 3'h2, 5);
    wr(`BTG_FREQ_MODE_OFS, 8'h00);
    $display("test abort done");
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (4) @(negedge clk_sys);
    rst_n = 1'b1;
    t_reset();
    t_regs();
    t_bursts(3, 1, 2, 3'h5, 2);
    t_bursts(0, 0, 0, 3'h1, 2);
    t_cont();
    t_abort();
    report_and_stop();
  end
endmodule // btg_top_tb_top
